// ==== lrs_params.svh ====
`ifndef LRS_PARAMS_SVH
`define LRS_PARAMS_SVH
`define LRS_REG_CTL        8'h6e
`define LRS_REG_ADDR       8'h6f
`define LRS_REG_DATA_FIRST 8'h70
`define LRS_REG_DATA_LAST  8'h78
`define LRS_CTL_READ_BIT   4
`define LRS_SEL_LEARNED    2'h2
`define LRS_SEL_COUNTERS   2'h3
`define LRS_BIT_VOID       71
`define LRS_CNT_HI         70
`define LRS_CNT_LO         61
`define LRS_BIT_PEND       55
`define LRS_BIT_OVF        31
`define LRS_BIT_VALID      30
`define LRS_VOID_RESET     1'b1
`define LRS_DATA_RESET     72'h80_0000_0000_0000_0000
`define LRS_PORT_LAST      3'h4
`define LRS_OFS_RX_LO      5'h00
`define LRS_OFS_RX_HI      5'h01
`define LRS_OFS_RX_SHORT   5'h02
`define LRS_OFS_RX_FRAG    5'h03
`define LRS_OFS_RX_LONG    5'h04
`define LRS_OFS_RX_JAB     5'h05
`define LRS_OFS_RX_SYM     5'h06
`define LRS_OFS_RX_CRC     5'h07
`define LRS_OFS_RX_ALIGN   5'h08
`define LRS_OFS_RX_CTRL    5'h09
`define LRS_OFS_RX_PAUSE   5'h0a
`define LRS_OFS_RX_BCAST   5'h0b
`define LRS_OFS_RX_MCAST   5'h0c
`define LRS_OFS_RX_UCAST   5'h0d
`define LRS_OFS_BIN_FIRST  5'h0e
`define LRS_OFS_TX_LO      5'h14
`define LRS_OFS_TX_HI      5'h15
`define LRS_OFS_TX_LATE    5'h16
`define LRS_OFS_TX_PAUSE   5'h17
`define LRS_OFS_TX_BCAST   5'h18
`define LRS_OFS_TX_MCAST   5'h19
`define LRS_OFS_TX_UCAST   5'h1a
`define LRS_OFS_TX_DEFER   5'h1b
`define LRS_OFS_TX_COLL    5'h1c
`define LRS_OFS_TX_XCOLL   5'h1d
`define LRS_OFS_TX_ONE     5'h1e
`define LRS_OFS_TX_MANY    5'h1f
`define LRS_LEN_MIN        11'h040
`define LRS_LEN_128        11'h080
`define LRS_LEN_256        11'h100
`define LRS_LEN_512        11'h200
`define LRS_LEN_1024       11'h400
`define LRS_LEN_STD        11'h5f2
`define LRS_LEN_LONG       11'h600
`define LRS_LEN_HUGE       11'h77c
`endif

// ==== lrs_pkg.sv ====
package lrs_pkg;
  typedef enum logic [1:0] {
    LRS_SIZE_STD  = 2'b00,
    LRS_SIZE_LONG = 2'b01,
    LRS_SIZE_HUGE = 2'b10
  } lrs_size_e;

  typedef enum logic [1:0] {
    LRS_IDLE     = 2'b00,
    LRS_TBL_WAIT = 2'b01,
    LRS_CNT_WAIT = 2'b10
  } lrs_state_e;

  typedef struct packed {
    logic [10:0] len;
    logic        hiPrio;
    logic        crcBad;
    logic        fracByte;
    logic        symErr;
    logic        bcast;
    logic        mcast;
    logic        ctrl8808;
    logic        pauseOp;
  } lrs_rx_frame_s;

  typedef struct packed {
    logic [10:0] len;
    logic        hiPrio;
    logic        good;
    logic        pause;
    logic        bcast;
    logic        mcast;
    logic        deferred;
    logic        excessive;
    logic [4:0]  collisions;
  } lrs_tx_frame_s;

  typedef struct packed {
    logic [1:0]  aging;
    logic [2:0]  port;
    logic [6:0]  filterGroupId;
    logic [47:0] mac;
  } lrs_entry_s;

  typedef struct packed {
    logic       write;
    logic       keep;
    logic [9:0] addr;
    lrs_entry_s entry;
  } lrs_learn_s;
endpackage : lrs_pkg

// ==== lrs_entry_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrs_entry_ram #(
  parameter int W     = 60,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic          clk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  input  wire logic          rdEn,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [W-1:0]  rdData
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("lrs_entry_ram: DEPTH exceeds address range");
  end

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read-first: a same-cycle write shows on the next read
  always_ff @(posedge clk) begin
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : lrs_entry_ram
`default_nettype wire

// ==== lrs_port_stats.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lrs_params.svh"
module lrs_port_stats #(
  parameter int CW = 30
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   rxDone,
  input  wire lrs_pkg::lrs_rx_frame_s rxInfo,
  input  wire logic                   txDone,
  input  wire lrs_pkg::lrs_tx_frame_s txInfo,
  input  wire logic                   txLateColl,
  input  wire logic                   txColl,
  input  wire lrs_pkg::lrs_size_e     sizeMode,
  input  wire logic                   rdStrobe,
  input  wire logic [4:0]             rdOffset,
  output logic      [31:0]            rdData
);
  logic [CW-1:0] cnt [32];
  logic [31:0]   ovf;
  logic [CW-1:0] inc [32];
  logic [10:0]   maxLen;
  logic          rxBad;
  logic          rxGood;
  logic          rxLegal;

  if (CW < 12 || CW > 30) begin : g_chk
    $error("lrs_port_stats: CW must be 12..30");
  end

  always_comb begin
    unique case (sizeMode)
      lrs_pkg::LRS_SIZE_LONG: maxLen = `LRS_LEN_LONG;
      lrs_pkg::LRS_SIZE_HUGE: maxLen = `LRS_LEN_HUGE;
      default:                maxLen = `LRS_LEN_STD;
    endcase
  end

  assign rxBad   = rxInfo.crcBad | rxInfo.fracByte | rxInfo.symErr;
  assign rxLegal = rxInfo.len >= `LRS_LEN_MIN && rxInfo.len <= maxLen;
  assign rxGood  = !rxBad && rxLegal;

  // Every event lands in the same cycle it arrives
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      inc[i] = '0;
    end
    if (rxDone) begin
      if (rxInfo.hiPrio) inc[`LRS_OFS_RX_HI] = CW'(rxInfo.len);
      else inc[`LRS_OFS_RX_LO] = CW'(rxInfo.len);
      inc[`LRS_OFS_RX_SHORT] = CW'(rxInfo.len < `LRS_LEN_MIN && !rxBad);
      inc[`LRS_OFS_RX_FRAG]  = CW'(rxInfo.len < `LRS_LEN_MIN && rxBad);
      inc[`LRS_OFS_RX_LONG]  = CW'(rxInfo.len > maxLen && !rxBad);
      inc[`LRS_OFS_RX_JAB]   = CW'(sizeMode == lrs_pkg::LRS_SIZE_HUGE ? rxInfo.len > `LRS_LEN_HUGE
                                   : rxInfo.len > `LRS_LEN_STD && rxBad);
      inc[`LRS_OFS_RX_SYM]   = CW'(rxInfo.symErr && rxLegal);
      inc[`LRS_OFS_RX_CRC]   = CW'(rxLegal && rxInfo.crcBad && !rxInfo.fracByte);
      inc[`LRS_OFS_RX_ALIGN] = CW'(rxLegal && rxInfo.crcBad && rxInfo.fracByte);
      inc[`LRS_OFS_RX_CTRL]  = CW'(rxInfo.ctrl8808);
      inc[`LRS_OFS_RX_PAUSE] = CW'(rxInfo.ctrl8808 && rxInfo.pauseOp && rxGood);
      inc[`LRS_OFS_RX_BCAST] = CW'(rxGood && rxInfo.bcast);
      inc[`LRS_OFS_RX_MCAST] = CW'(rxGood && !rxInfo.bcast && rxInfo.mcast && !rxInfo.ctrl8808);
      inc[`LRS_OFS_RX_UCAST] = CW'(rxGood && !rxInfo.bcast && !rxInfo.mcast);
      inc[`LRS_OFS_BIN_FIRST]   = CW'(rxInfo.len == `LRS_LEN_MIN);
      inc[`LRS_OFS_BIN_FIRST+1] = CW'(rxInfo.len > `LRS_LEN_MIN && rxInfo.len < `LRS_LEN_128);
      inc[`LRS_OFS_BIN_FIRST+2] = CW'(rxInfo.len >= `LRS_LEN_128 && rxInfo.len < `LRS_LEN_256);
      inc[`LRS_OFS_BIN_FIRST+3] = CW'(rxInfo.len >= `LRS_LEN_256 && rxInfo.len < `LRS_LEN_512);
      inc[`LRS_OFS_BIN_FIRST+4] = CW'(rxInfo.len >= `LRS_LEN_512 && rxInfo.len < `LRS_LEN_1024);
      inc[`LRS_OFS_BIN_FIRST+5] = CW'(rxInfo.len >= `LRS_LEN_1024 && rxInfo.len <= maxLen);
    end
    if (txDone) begin
      if (txInfo.good && txInfo.hiPrio) inc[`LRS_OFS_TX_HI] = CW'(txInfo.len);
      if (txInfo.good && !txInfo.hiPrio) inc[`LRS_OFS_TX_LO] = CW'(txInfo.len);
      inc[`LRS_OFS_TX_PAUSE] = CW'(txInfo.good && txInfo.pause);
      inc[`LRS_OFS_TX_BCAST] = CW'(txInfo.good && txInfo.bcast);
      inc[`LRS_OFS_TX_MCAST] = CW'(txInfo.good && !txInfo.bcast && txInfo.mcast);
      inc[`LRS_OFS_TX_UCAST] = CW'(txInfo.good && !txInfo.bcast && !txInfo.mcast);
      inc[`LRS_OFS_TX_DEFER] = CW'(txInfo.deferred);
      inc[`LRS_OFS_TX_XCOLL] = CW'(txInfo.excessive);
      inc[`LRS_OFS_TX_ONE]   = CW'(txInfo.good && txInfo.collisions == 5'h01);
      inc[`LRS_OFS_TX_MANY]  = CW'(txInfo.good && txInfo.collisions > 5'h01);
    end
    inc[`LRS_OFS_TX_LATE] = CW'(txLateColl);
    inc[`LRS_OFS_TX_COLL] = CW'(txColl);
  end

  for (genvar i = 0; i < 32; i++) begin : g_cnt
    logic          clr;
    logic [CW:0]   sum;
    assign clr = rdStrobe && rdOffset == 5'(i);
    assign sum = {1'b0, cnt[i]} + {1'b0, inc[i]};
    // Clear on read keeps a same-cycle event
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt[i] <= '0;
        ovf[i] <= 1'b0;
      end else if (clr) begin
        cnt[i] <= inc[i];
        ovf[i] <= 1'b0;
      end else begin
        cnt[i] <= sum[CW-1:0];
        ovf[i] <= ovf[i] | sum[CW];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= '0;
    end else if (rdStrobe) begin
      rdData <= {ovf[rdOffset], 1'b1, 30'(cnt[rdOffset])};
    end
  end

  a_read_clears: assert property (@(posedge clk) disable iff (!reset_n)
    rdStrobe |=> cnt[$past(rdOffset)] == $past(inc[rdOffset]))
    else $error("counter not cleared by read");
  a_bcast_step: assert property (@(posedge clk) disable iff (!reset_n)
    rxDone && rxGood && rxInfo.bcast && !(rdStrobe && rdOffset == `LRS_OFS_RX_BCAST)
    |=> cnt[`LRS_OFS_RX_BCAST] == $past(cnt[`LRS_OFS_RX_BCAST]) + CW'(1))
    else $error("broadcast count did not step by one");
  a_octets_add: assert property (@(posedge clk) disable iff (!reset_n)
    rxDone && !rxInfo.hiPrio && !rdStrobe && !cnt[`LRS_OFS_RX_LO][CW-1]
    |=> cnt[`LRS_OFS_RX_LO] == $past(cnt[`LRS_OFS_RX_LO]) + CW'($past(rxInfo.len)))
    else $error("rx octets not added");
endmodule : lrs_port_stats
`default_nettype wire

// ==== lrs_readout.sv ====
// How it works
// - Only the learning logic writes the learned table; host reads never change it.
// - Bit 71 reads 1 when the table is empty, else 0; resets to 1.
// - Bits 70-61 carry valid entries minus one, read with the empty flag.
// - Bits 60-59 hold each entry's 2-bit aging counter.
// - Bits 58-56 give the learning port, codes 0 to 4 for ports 1 to 5.
// - Bit 55 reads 1 until the requested entry is ready, then 0.
// - Upper entry address bits come from the low bits of the control value.
// - Nine data registers give the 72-bit entry, high byte first.
// - Each port has 32 counters reached by indirect index 0x0 to 0x1F.
// - Rx octets count all frames by priority; tx octets count good frames.
// - Short good, short bad and long good frames each have a counter.
// - Long errored frames, or frames over 1916 in huge mode, are counted.
// - Symbol errors, whole-byte and fractional-byte checksum errors are counted.
// - Control frames and qualified pause frames are counted.
// - Good broadcast, multicast and unicast frames counted exclusively.
// - Frames from 64 bytes up to the size limit counted into six length bins.
// - Late collisions past 512 bit-times are counted.
// - Tx pause, broadcast, multicast and unicast frames are counted.
// - Deferrals, collisions, give-ups, one and many collision successes counted.
// - Counter reads as overflow, valid, then a 30-bit count.
// - Reading a counter clears it.
// - Each later port adds 0x20 to the counter index.
`timescale 1ns/1ps
`default_nettype none
`include "lrs_params.svh"
module lrs_readout #(
  parameter int PORTS = 5,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic                               clk,
  input  wire logic                               reset_n,
  input  wire logic                               regWrite,
  input  wire logic                               regRead,
  input  wire logic [7:0]                         regAddr,
  input  wire logic [7:0]                         regWrData,
  output logic      [7:0]                         regRdData,
  output logic                                    regRdValid,
  input  wire lrs_pkg::lrs_learn_s                lrnUpdate,
  input  wire lrs_pkg::lrs_size_e                 sizeMode,
  input  wire logic [PORTS-1:0]                   rxDone,
  input  wire lrs_pkg::lrs_rx_frame_s [PORTS-1:0] rxInfo,
  input  wire logic [PORTS-1:0]                   txDone,
  input  wire lrs_pkg::lrs_tx_frame_s [PORTS-1:0] txInfo,
  input  wire logic [PORTS-1:0]                   txLateColl,
  input  wire logic [PORTS-1:0]                   txColl,
  output logic                                    tableVoid,
  output logic                                    readPending
);
  lrs_pkg::lrs_state_e state;
  lrs_pkg::lrs_state_e next_state;
  lrs_pkg::lrs_entry_s ramQ;
  logic [7:0]          ctl;
  logic [7:0]          addrLow;
  logic [71:0]         dataBuf;
  logic [71:0]         dataView;
  logic [DEPTH-1:0]    validMap;
  logic [AW:0]         validCount;
  logic [AW:0]         next_validCount;
  logic [AW-1:0]       countMinusOne;
  logic                trigger;
  logic                trigTable;
  logic                trigCounter;
  logic [AW-1:0]       tableIdx;
  logic [7:0]          counterIdx;
  logic [2:0]          capPort;
  logic [PORTS-1:0]    portRd;
  logic [31:0]         portData [PORTS];
  logic [3:0]          byteSel;
  logic [6:0]          byteBase;
  logic                isData;

  if (PORTS != 5 || AW != 10 || DEPTH != 1024) begin : g_chk
    $error("lrs_readout: layout fixed at 5 ports and 1K entries");
  end

  // Indirect access decode
  assign trigger     = regWrite && regAddr == `LRS_REG_ADDR && ctl[`LRS_CTL_READ_BIT];
  assign trigTable   = trigger && ctl[3:2] == `LRS_SEL_LEARNED && state == lrs_pkg::LRS_IDLE;
  assign trigCounter = trigger && ctl[3:2] == `LRS_SEL_COUNTERS && state == lrs_pkg::LRS_IDLE;
  assign tableIdx    = {ctl[1:0], regWrData};
  assign counterIdx  = regWrData;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= '0;
    end else if (regWrite && regAddr == `LRS_REG_CTL) begin
      ctl <= regWrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addrLow <= '0;
    end else if (regWrite && regAddr == `LRS_REG_ADDR) begin
      addrLow <= regWrData;
    end
  end

  // Learned table: written only by the learning logic
  lrs_entry_ram #(
    .W     (60),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_ram (
    .clk    (clk),
    .wrEn   (lrnUpdate.write && lrnUpdate.keep),
    .wrAddr (lrnUpdate.addr),
    .wrData (lrnUpdate.entry),
    .rdEn   (trigTable),
    .rdAddr (tableIdx),
    .rdData (ramQ)
  );

  // Valid bitmap lets the count move without a read-modify-write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      validMap <= '0;
    end else if (lrnUpdate.write) begin
      validMap[lrnUpdate.addr] <= lrnUpdate.keep;
    end
  end

  always_comb begin
    next_validCount = validCount;
    if (lrnUpdate.write && lrnUpdate.keep && !validMap[lrnUpdate.addr]) begin
      next_validCount = validCount + (AW+1)'(1);
    end else if (lrnUpdate.write && !lrnUpdate.keep && validMap[lrnUpdate.addr]) begin
      next_validCount = validCount - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      validCount <= '0;
      tableVoid  <= `LRS_VOID_RESET;
    end else begin
      validCount <= next_validCount;
      tableVoid  <= next_validCount == '0;
    end
  end

  // Zero entries and one entry both read 0 here; the void flag tells them apart
  assign countMinusOne = (validCount == '0) ? '0 : AW'(validCount - (AW+1)'(1));

  // Counter blocks, one per port
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    assign portRd[p] = trigCounter && counterIdx[7:5] == 3'(p);
    lrs_port_stats #(
      .CW (30)
    ) u_stats (
      .clk        (clk),
      .reset_n    (reset_n),
      .rxDone     (rxDone[p]),
      .rxInfo     (rxInfo[p]),
      .txDone     (txDone[p]),
      .txInfo     (txInfo[p]),
      .txLateColl (txLateColl[p]),
      .txColl     (txColl[p]),
      .sizeMode   (sizeMode),
      .rdStrobe   (portRd[p]),
      .rdOffset   (counterIdx[4:0]),
      .rdData     (portData[p])
    );
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capPort <= '0;
    end else if (trigCounter) begin
      capPort <= counterIdx[7:5];
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      lrs_pkg::LRS_IDLE: begin
        if (trigTable) next_state = lrs_pkg::LRS_TBL_WAIT;
        else if (trigCounter) next_state = lrs_pkg::LRS_CNT_WAIT;
      end
      lrs_pkg::LRS_TBL_WAIT: next_state = lrs_pkg::LRS_IDLE;
      lrs_pkg::LRS_CNT_WAIT: next_state = lrs_pkg::LRS_IDLE;
      default: next_state = lrs_pkg::LRS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= lrs_pkg::LRS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readPending <= 1'b0;
    end else if (trigTable) begin
      readPending <= 1'b1;
    end else if (state == lrs_pkg::LRS_TBL_WAIT) begin
      readPending <= 1'b0;
    end
  end

  // Entry and count are captured together so the host sees one snapshot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataBuf <= `LRS_DATA_RESET;
    end else if (state == lrs_pkg::LRS_TBL_WAIT) begin
      dataBuf <= {tableVoid, countMinusOne, ramQ.aging, ramQ.port, 1'b0,
                  ramQ.filterGroupId, ramQ.mac};
    end else if (state == lrs_pkg::LRS_CNT_WAIT) begin
      dataBuf <= {40'h0, (capPort <= `LRS_PORT_LAST) ? portData[capPort] : 32'h0};
    end
  end

  // Register read path
  assign dataView = dataBuf | ({71'h0, readPending} << `LRS_BIT_PEND);
  assign isData   = regAddr >= `LRS_REG_DATA_FIRST && regAddr <= `LRS_REG_DATA_LAST;
  assign byteSel  = 4'(regAddr - `LRS_REG_DATA_FIRST);
  assign byteBase = 7'({3'h0, 4'h8 - byteSel} << 3);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData  <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        if (regAddr == `LRS_REG_CTL) regRdData <= ctl;
        else if (regAddr == `LRS_REG_ADDR) regRdData <= addrLow;
        else if (isData) regRdData <= dataView[byteBase +: 8];
        else regRdData <= '0;
      end
    end
  end

  // Bus answer, byte map and control store
  a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
    regRdValid == $past(regRead))
    else $error("read answer not one cycle after request");

  a_first_byte: assert property (@(posedge clk) disable iff (!reset_n)
    regRead && regAddr == `LRS_REG_DATA_FIRST |=> regRdData == $past(dataView[71:64]))
    else $error("first data byte is not the top of the entry");

  a_ctl_store: assert property (@(posedge clk) disable iff (!reset_n)
    regWrite && regAddr == `LRS_REG_CTL |=> ctl == $past(regWrData))
    else $error("control write not stored");

  // Sequencer, table and counter snapshot
  a_one_wait: assert property (@(posedge clk) disable iff (!reset_n)
    state != lrs_pkg::LRS_IDLE |=> state == lrs_pkg::LRS_IDLE)
    else $error("sequencer stayed busy");

  a_pending_window: assert property (@(posedge clk) disable iff (!reset_n)
    trigTable |=> readPending ##1 !readPending)
    else $error("pending bit window wrong");

  a_wait_pending: assert property (@(posedge clk) disable iff (!reset_n)
    state == lrs_pkg::LRS_TBL_WAIT |-> readPending)
    else $error("table wait without pending bit");

  a_void_tracks: assert property (@(posedge clk) disable iff (!reset_n)
    tableVoid == (validCount == '0))
    else $error("void flag disagrees with count");

  a_void_steady: assert property (@(posedge clk) disable iff (!reset_n)
    !lrnUpdate.write |=> $stable(tableVoid))
    else $error("void flag moved without learning");

  a_map_count: assert property (@(posedge clk) disable iff (!reset_n)
    validCount == $countones(validMap))
    else $error("entry count disagrees with valid map");

  a_count_field: assert property (@(posedge clk) disable iff (!reset_n)
    state == lrs_pkg::LRS_TBL_WAIT |=> dataBuf[`LRS_CNT_HI:`LRS_CNT_LO] == $past(countMinusOne)
      && dataBuf[`LRS_BIT_VOID] == $past(tableVoid))
    else $error("count field not captured");

  a_high_addr: assert property (@(posedge clk) disable iff (!reset_n)
    trigTable |-> tableIdx[AW-1:8] == ctl[1:0])
    else $error("upper address bits lost");

  a_counter_valid: assert property (@(posedge clk) disable iff (!reset_n)
    trigCounter && regWrData[7:5] <= `LRS_PORT_LAST |=> ##1 dataBuf[`LRS_BIT_VALID])
    else $error("counter readout not marked valid");

  a_counter_snapshot: assert property (@(posedge clk) disable iff (!reset_n)
    state == lrs_pkg::LRS_CNT_WAIT && capPort <= `LRS_PORT_LAST
    |=> dataBuf == {40'h0, $past(portData[capPort])})
    else $error("counter snapshot not captured");

  a_no_host_write: assert property (@(posedge clk) disable iff (!reset_n)
    !lrnUpdate.write |=> validCount == $past(validCount))
    else $error("table count moved without learning");
endmodule : lrs_readout
`default_nettype wire

// ==== lrs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrs_host_model (
  input  wire logic       clk,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid,
  output logic            timedOut
);
  initial begin
    {regWrite, regRead, regAddr, regWrData, timedOut} = 19'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {regWrite, regAddr, regWrData} = {1'b1, a, d};
    @(negedge clk);
    regWrite = 1'b0;
    regWrData = ~d; // Released lines must not keep the last value
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    {regRead, regAddr} = {1'b1, a};
    @(negedge clk);
    regRead = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && regRdValid !== 1'b1; n++) @(negedge clk);
    if (n == 4) timedOut = 1'b1;
    else d = regRdData;
  endtask : rd
  task automatic rdEntry(input logic [7:0] ctl, input logic [7:0] a, output logic [71:0] e);
    logic [7:0] b;
    int         i;
    wr(8'h6e, ctl);
    wr(8'h6f, a);
    rd(8'h70, e[71:64]);
    rd(8'h71, e[63:56]);
    b = 8'h80;
    for (i = 0; i < 8 && b[7]; i++) rd(8'h72, b);
    if (b[7]) timedOut = 1'b1;
    e[55:48] = b;
    for (i = 3; i < 9; i++) begin
      rd(8'h70 + i[7:0], b);
      e[71-8*i -: 8] = b;
    end
  endtask : rdEntry
endmodule : lrs_host_model
`default_nettype wire

// ==== lrs_readout_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrs_readout_tb;
  logic                         clk;
  logic                         reset_n;
  logic                         regWrite;
  logic                         regRead;
  logic [7:0]                   regAddr;
  logic [7:0]                   regWrData;
  logic [7:0]                   regRdData;
  logic                         regRdValid;
  lrs_pkg::lrs_learn_s          lrnUpdate;
  logic [4:0]                   rxDone;
  lrs_pkg::lrs_rx_frame_s [4:0] rxInfo;
  logic [4:0]                   txDone;
  lrs_pkg::lrs_tx_frame_s [4:0] txInfo;
  logic [4:0]                   txLateColl;
  logic [4:0]                   txColl;
  lrs_pkg::lrs_size_e           sizeMode;
  logic                         tableVoid;
  logic                         readPending;
  logic                         timedOut;
  logic [71:0]                  ent;
  int                           n_errors;
  int                           n_checks;
  localparam logic [59:0] E1 = 60'ha55_0123_4567_89ab;

  lrs_readout dut (.clk(clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .lrnUpdate(lrnUpdate),
    .sizeMode(sizeMode), .rxDone(rxDone), .rxInfo(rxInfo), .txDone(txDone), .txInfo(txInfo),
    .txLateColl(txLateColl), .txColl(txColl), .tableVoid(tableVoid), .readPending(readPending));
  lrs_host_model h (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .timedOut(timedOut));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done;
    if (timedOut) n_errors++;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic learn(input logic keep, input logic [9:0] a, input logic [59:0] e);
    @(negedge clk);
    lrnUpdate = lrs_pkg::lrs_learn_s'({1'b1, keep, a, e});
    @(negedge clk);
    lrnUpdate.write = 1'b0;
  endtask : learn
  task automatic cnt(input logic [7:0] idx, input logic [29:0] n);
    logic [7:0]  b;
    logic [31:0] v;
    h.wr(8'h6e, 8'h1c);
    h.wr(8'h6f, idx);
    repeat (2) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      h.rd(8'h75 + i[7:0], b);
      v = {v[23:0], b};
    end
    chk("counter", 72'(v), 72'({2'b01, n}));
  endtask : cnt
  // Port comes from the index bits above the offset
  task automatic rxc(input logic [18:0] f, input logic [7:0] idx, input logic [29:0] n);
    @(negedge clk);
    rxInfo[idx[7:5]] = lrs_pkg::lrs_rx_frame_s'(f);
    rxDone[idx[7:5]] = 1'b1;
    @(negedge clk);
    rxDone = 5'h00;
    cnt(idx, n);
  endtask : rxc
  task automatic txc(input logic [22:0] f, input logic [7:0] idx, input logic [29:0] n, input logic late);
    @(negedge clk);
    txInfo[idx[7:5]] = lrs_pkg::lrs_tx_frame_s'(f);
    {txDone[idx[7:5]], txLateColl[idx[7:5]]} = {~late, late};
    @(negedge clk);
    {txDone, txLateColl} = 10'h000;
    cnt(idx, n);
  endtask : txc
  task automatic t_table;
    chk("void", 72'(tableVoid), 72'h1);
    h.rdEntry(8'h18, 8'h00, ent);
    chk("empty", 72'(ent[71:61]), 72'h400);
    learn(1'b1, 10'h000, 60'h001);
    learn(1'b1, 10'h101, E1);
    @(negedge clk);
    chk("void", 72'(tableVoid), 72'h0);
    h.wr(8'h6e, 8'h19);
    h.wr(8'h6f, 8'h01);
    chk("pending", 72'(readPending), 72'h1);
    for (int i = 0; i < 2; i++) begin
      h.rdEntry(8'h19, 8'h01, ent);
      chk("entry", ent, {1'b0, 10'h001, E1[59:55], 1'b0, E1[54:0]});
    end
    learn(1'b0, 10'h000, 60'h001);
    learn(1'b0, 10'h101, E1);
    @(negedge clk);
    chk("void", 72'(tableVoid), 72'h1);
    $display("table test done");
  endtask : t_table
  task automatic t_rx;
    rxc({11'h040, 8'h00}, 8'h00, 30'h40);
    rxc({11'h040, 8'h00}, 8'h0d, 30'h2);
    rxc({11'h040, 8'h00}, 8'h0e, 30'h3);
    rxc({11'h040, 8'h00}, 8'h00, 30'hc0);
    rxc({11'h064, 8'h88}, 8'h01, 30'h64);
    rxc({11'h064, 8'h88}, 8'h0b, 30'h2);
    rxc({11'h064, 8'h40}, 8'h07, 30'h1);
    rxc({11'h064, 8'h60}, 8'h08, 30'h1);
    rxc({11'h064, 8'h10}, 8'h06, 30'h1);
    rxc({11'h028, 8'h00}, 8'h02, 30'h1);
    rxc({11'h028, 8'h40}, 8'h03, 30'h1);
    rxc({11'h5fa, 8'h00}, 8'h04, 30'h1);
    rxc({11'h640, 8'h40}, 8'h05, 30'h1);
    rxc({11'h040, 8'h07}, 8'h0a, 30'h1);
    rxc({11'h040, 8'h07}, 8'h09, 30'h2);
    rxc({11'h040, 8'h07}, 8'h0c, 30'h0);
    rxc({11'h44c, 8'h00}, 8'h13, 30'h1);
    rxc({11'h040, 8'h00}, 8'h6e, 30'h1);
    sizeMode = lrs_pkg::LRS_SIZE_LONG;
    rxc({11'h5fa, 8'h00}, 8'h13, 30'h1);
    sizeMode = lrs_pkg::LRS_SIZE_HUGE;
    rxc({11'h780, 8'h00}, 8'h05, 30'h1);
    sizeMode = lrs_pkg::LRS_SIZE_STD;
    $display("receive counter test done");
  endtask : t_rx
  task automatic t_tx;
    txc({11'h040, 7'h20, 5'h00}, 8'h94, 30'h40, 1'b0);
    txc({11'h040, 7'h20, 5'h00}, 8'h9a, 30'h2, 1'b0);
    txc({11'h040, 7'h28, 5'h00}, 8'h98, 30'h1, 1'b0);
    txc({11'h040, 7'h24, 5'h00}, 8'h99, 30'h1, 1'b0);
    txc({11'h040, 7'h30, 5'h00}, 8'h97, 30'h1, 1'b0);
    txc({11'h040, 7'h22, 5'h00}, 8'h9b, 30'h1, 1'b0);
    txc({11'h040, 7'h01, 5'h00}, 8'h9d, 30'h1, 1'b0);
    txc({11'h040, 7'h20, 5'h01}, 8'h9e, 30'h1, 1'b0);
    txc({11'h040, 7'h20, 5'h03}, 8'h9f, 30'h1, 1'b0);
    txc({11'h040, 7'h00, 5'h00}, 8'h96, 30'h1, 1'b1);
    @(negedge clk);
    txColl = 5'h10;
    @(negedge clk);
    txColl = 5'h00;
    cnt(8'h9c, 30'h1);
    $display("transmit counter test done");
  endtask : t_tx
  initial begin
    {reset_n, rxDone, txDone, txLateColl, txColl, n_errors, n_checks} = '0;
    sizeMode = lrs_pkg::LRS_SIZE_STD;
    lrnUpdate = lrs_pkg::lrs_learn_s'(72'h0);
    rxInfo = '0;
    txInfo = '0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    t_table();
    t_rx();
    t_tx();
    test_done();
  end
endmodule : lrs_readout_tb
`default_nettype wire
